/* prr_regs.svh */
// Address map and reset values for the page-zero RAM decoder.
// Assumes a 14-bit processor address and 8-bit data.
`ifndef PRR_REGS_SVH
`define PRR_REGS_SVH

`define PRR_ADDR_W 14
`define PRR_FAST_RAM_LO 14'h0000
`define PRR_FAST_RAM_HI 14'h000e
`define PRR_DATA_PORT 14'h000e
`define PRR_INDEX_PTR 14'h000f
`define PRR_PERIPH_LO 14'h0010
`define PRR_PERIPH_HI 14'h001e
`define PRR_PAGE_SEL 14'h001f
`define PRR_RAM_LO 14'h0020
`define PRR_RAM_HI 14'h004f
`define PRR_RAM_SECOND_SHIFT 14'h0011
`define PRR_WIN_LO 14'h00c0
`define PRR_WIN_HI 14'h00ff
`define PRR_HIGH_REG_LO 14'h0200
`define PRR_HIGH_REG_HI 14'h023f
`define PRR_NVM_LO 14'h3800
`define PRR_NVM_HI 14'h3fff
`define PRR_INDEX_RESET 8'h00
`define PRR_PAGE_RESET 8'h00
`define PRR_RAM_BYTES 63
`define PRR_RAM_IDX_W 6
`define PRR_WIN_OFS_W 6
`define PRR_TINY_ADDR_W 4
`define PRR_SHORT_ADDR_W 5

`endif

/* prr_pkg.sv */
// Types shared by the page-zero RAM decoder files.
// Assumes nothing beyond the address map header.
`default_nettype none
`include "prr_regs.svh"

package prr_pkg;

    typedef enum logic [2:0] {
        PRR_TGT_RAM = 3'b000,
        PRR_TGT_INDEX = 3'b001,
        PRR_TGT_PAGE = 3'b010,
        PRR_TGT_PERIPH = 3'b011,
        PRR_TGT_NONE = 3'b100
    } prr_target_e;

    typedef enum logic {
        PRR_FORM_TINY = 1'b0,
        PRR_FORM_SHORT = 1'b1
    } prr_form_e;

    typedef struct packed {
        logic [7:0] indexPointer;
        logic [7:0] pageSelect;
        logic [7:0] readData;
        logic readValid;
        logic resetReq;
        logic [7:0] opAddr;
        logic opAddrValid;
    } prr_state_s;

    typedef struct packed {
        logic [`PRR_RAM_BYTES*8-1:0] mem;
    } prr_ram_s;

endpackage

`default_nettype wire

/* prr_ram.sv */
// Static RAM array of the page-zero decoder, held in flip-flops.
// Assumes one write port and an index that the decoder keeps in range.
`timescale 1ns/1ps
`default_nettype none
`include "prr_regs.svh"

module prr_ram #(
    parameter int Bytes = `PRR_RAM_BYTES
) (
    input wire logic clk,
    input wire logic writeEn,
    input wire logic [`PRR_RAM_IDX_W-1:0] index,
    input wire logic [7:0] writeData,
    output logic [7:0] readData
);

    prr_pkg::prr_ram_s state;
    prr_pkg::prr_ram_s next_state;

    // The array has no reset and no clear path, so contents survive every reset
    // and any stretch of stopped or idle clock.
    always_comb begin
        next_state = state;
        if (writeEn && (int'(index) < Bytes)) begin
            next_state.mem[index*8 +: 8] = writeData;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
    end

    assign readData = (int'(index) < Bytes) ? state.mem[index*8 +: 8] : 8'h00;

endmodule

`default_nettype wire

/* prr_decoder.sv */
// Page-zero data space decoder: fast RAM, indirect data port, index pointer,
// page select with its window, general RAM, and unimplemented holes.
// Assumes one synchronous processor bus with a single request per cycle.
//
// Overview of operation
// - Bytes 0x00 to 0x0D are static RAM.
// - Tiny form takes address from opcode byte.
// - Short form packs address into opcode byte.
// - RAM byte 0x0E reached via port, pointer 0x0E.
// - RAM byte 0x0E also at window 0xCE, page 0.
// - Second RAM section spans 0x20 to 0x4F.
// - RAM kept through wait and stop.
// - No reset touches RAM contents.
// - Port at 0x0E, pointer at 0x0F.
// - Index pointer cleared by every reset.
// - Pointer 0x0F makes port access the pointer.
// - Unimplemented address access requests device reset.
`timescale 1ns/1ps
`default_nettype none
`include "prr_regs.svh"

module prr_decoder #(
    parameter logic [13:0] NvmBase = `PRR_NVM_LO
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [13:0] busAddr,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic busFetch,
    input wire logic [7:0] busWdata,
    output logic [7:0] busRdata,
    output logic busRvalid,
    output logic resetRequest,
    input wire logic [7:0] opcodeByte,
    input wire logic opcodeValid,
    input wire prr_pkg::prr_form_e opcodeForm,
    output logic [7:0] operandAddr,
    output logic operandValid,
    output logic [13:0] periphAddr,
    output logic periphRead,
    output logic periphWrite,
    output logic [7:0] periphWdata,
    input wire logic [7:0] periphRdata
);

    prr_pkg::prr_state_s state;
    prr_pkg::prr_state_s next_state;
    prr_pkg::prr_target_e target;
    logic [13:0] effAddr;
    logic [13:0] physAddr;
    logic [13:0] ramOffset;
    logic [`PRR_RAM_IDX_W-1:0] ramIdx;
    logic [7:0] ramRdata;
    logic ramWrite;
    logic anyAccess;

    ////////////////////////////////////////////////////////////////////////////
    // Address resolution: the data port first, then the paging window.

    always_comb begin
        anyAccess = busRead || busWrite || busFetch;
        effAddr = busAddr;
        if (busAddr == `PRR_DATA_PORT) begin
            effAddr = 14'(state.indexPointer);
        end
        physAddr = effAddr;
        if (effAddr >= `PRR_WIN_LO && effAddr <= `PRR_WIN_HI) begin
            physAddr = {state.pageSelect, effAddr[`PRR_WIN_OFS_W-1:0]};
        end
        ramOffset = physAddr - `PRR_RAM_SECOND_SHIFT;
        ramIdx = physAddr[`PRR_RAM_IDX_W-1:0];
        if (physAddr <= `PRR_FAST_RAM_HI) begin
            // Physical 0x0E is only reached here through the port or the window.
            target = prr_pkg::PRR_TGT_RAM;
        end else if (physAddr == `PRR_INDEX_PTR) begin
            target = prr_pkg::PRR_TGT_INDEX;
        end else if (physAddr == `PRR_PAGE_SEL) begin
            target = prr_pkg::PRR_TGT_PAGE;
        end else if (physAddr >= `PRR_PERIPH_LO && physAddr <= `PRR_PERIPH_HI) begin
            target = prr_pkg::PRR_TGT_PERIPH;
        end else if (physAddr >= `PRR_RAM_LO && physAddr <= `PRR_RAM_HI) begin
            target = prr_pkg::PRR_TGT_RAM;
            ramIdx = ramOffset[`PRR_RAM_IDX_W-1:0];
        end else if ((physAddr >= `PRR_HIGH_REG_LO && physAddr <= `PRR_HIGH_REG_HI) ||
                     (physAddr >= NvmBase && physAddr <= `PRR_NVM_HI)) begin
            target = prr_pkg::PRR_TGT_PERIPH;
        end else begin
            target = prr_pkg::PRR_TGT_NONE;
        end
    end

    assign ramWrite = busWrite && (target == prr_pkg::PRR_TGT_RAM);
    assign periphAddr = physAddr;
    assign periphRead = (busRead || busFetch) && (target == prr_pkg::PRR_TGT_PERIPH);
    assign periphWrite = busWrite && (target == prr_pkg::PRR_TGT_PERIPH);
    assign periphWdata = busWdata;

    prr_ram #(
        .Bytes(`PRR_RAM_BYTES)
    ) u_ram (
        .clk(clk),
        .writeEn(ramWrite),
        .index(ramIdx),
        .writeData(busWdata),
        .readData(ramRdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers, read return, reset request and operand decode.

    always_comb begin
        next_state = state;
        next_state.readValid = busRead || busFetch;
        next_state.resetReq = anyAccess && (target == prr_pkg::PRR_TGT_NONE);
        if (busRead || busFetch) begin
            unique case (target)
                prr_pkg::PRR_TGT_RAM: next_state.readData = ramRdata;
                prr_pkg::PRR_TGT_INDEX: next_state.readData = state.indexPointer;
                prr_pkg::PRR_TGT_PAGE: next_state.readData = state.pageSelect;
                prr_pkg::PRR_TGT_PERIPH: next_state.readData = periphRdata;
                prr_pkg::PRR_TGT_NONE: next_state.readData = 8'h00;
            endcase
        end
        if (busWrite && target == prr_pkg::PRR_TGT_INDEX) begin
            next_state.indexPointer = busWdata;
        end
        if (busWrite && target == prr_pkg::PRR_TGT_PAGE) begin
            next_state.pageSelect = busWdata;
        end
        next_state.opAddrValid = opcodeValid;
        if (opcodeValid) begin
            unique case (opcodeForm)
                prr_pkg::PRR_FORM_TINY: next_state.opAddr = 8'(opcodeByte[`PRR_TINY_ADDR_W-1:0]);
                prr_pkg::PRR_FORM_SHORT: next_state.opAddr = 8'(opcodeByte[`PRR_SHORT_ADDR_W-1:0]);
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state.indexPointer <= `PRR_INDEX_RESET;
            state.pageSelect <= `PRR_PAGE_RESET;
            state.readData <= 8'h00;
            state.readValid <= 1'b0;
            state.resetReq <= 1'b0;
            state.opAddr <= 8'h00;
            state.opAddrValid <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign busRdata = state.readData;
    assign busRvalid = state.readValid;
    assign resetRequest = state.resetReq;
    assign operandAddr = state.opAddr;
    assign operandValid = state.opAddrValid;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_INDEX_CLEARED: assert property (@(posedge clk) $rose(rst_b) |-> state.indexPointer == 8'h00)
        else $error("Index pointer not zero after reset.");

    AST_HOLE_RESETS: assert property (@(posedge clk) disable iff (!rst_b)
        anyAccess && target == prr_pkg::PRR_TGT_NONE |=> resetRequest)
        else $error("Unimplemented access gave no reset request.");

    AST_PORT_READS_POINTER: assert property (@(posedge clk) disable iff (!rst_b)
        busRead && busAddr == `PRR_DATA_PORT && state.indexPointer == 8'h0f
        |=> busRvalid && busRdata == 8'h0f)
        else $error("Port read at pointer 0x0f did not return pointer.");

    AST_PORT_WRITES_POINTER: assert property (@(posedge clk) disable iff (!rst_b)
        busWrite && busAddr == `PRR_DATA_PORT && state.indexPointer == 8'h0f
        |=> state.indexPointer == $past(busWdata))
        else $error("Port write at pointer 0x0f did not update pointer.");

    AST_WINDOW_PHYS: assert property (@(posedge clk) disable iff (!rst_b)
        busAddr >= `PRR_WIN_LO && busAddr <= `PRR_WIN_HI
        |-> physAddr == {state.pageSelect, busAddr[5:0]})
        else $error("Window address not formed from page select.");

    AST_PORT_RAM_0E: assert property (@(posedge clk) disable iff (!rst_b)
        busAddr == `PRR_DATA_PORT && state.indexPointer == 8'h0e
        |-> target == prr_pkg::PRR_TGT_RAM && ramIdx == 6'h0e)
        else $error("Port at pointer 0x0e missed RAM byte 0x0e.");

    AST_WINDOW_RAM_0E: assert property (@(posedge clk) disable iff (!rst_b)
        busAddr == 14'h00ce && state.pageSelect == 8'h00
        |-> target == prr_pkg::PRR_TGT_RAM && ramIdx == 6'h0e)
        else $error("Window 0xce at page 0 missed RAM byte 0x0e.");

    AST_SECOND_RAM: assert property (@(posedge clk) disable iff (!rst_b)
        busAddr >= `PRR_RAM_LO && busAddr <= `PRR_RAM_HI
        |-> target == prr_pkg::PRR_TGT_RAM && ramIdx == 6'(busAddr - 14'h0011))
        else $error("Second RAM section decoded wrongly.");

    AST_FAST_RAM_ROUNDTRIP: assert property (@(posedge clk) disable iff (!rst_b)
        (busWrite && busAddr == 14'h0005) ##1 (busRead && !busWrite && busAddr == 14'h0005)
        |=> busRdata == $past(busWdata, 2))
        else $error("Fast RAM byte did not return written value.");

    AST_TINY_OPERAND: assert property (@(posedge clk) disable iff (!rst_b)
        opcodeValid && opcodeForm == prr_pkg::PRR_FORM_TINY
        |=> operandValid && operandAddr == {4'h0, $past(opcodeByte[3:0])})
        else $error("Tiny operand address wrong.");

    AST_SHORT_OPERAND: assert property (@(posedge clk) disable iff (!rst_b)
        opcodeValid && opcodeForm == prr_pkg::PRR_FORM_SHORT
        |=> operandValid && operandAddr == {3'h0, $past(opcodeByte[4:0])})
        else $error("Short operand address wrong.");

endmodule

`default_nettype wire

/* prr_periph_model.sv */
// Peripheral register space seen by the page-zero decoder.
// Assumes the decoder's combinational periph* outputs and one clock.
`timescale 1ns/1ps
`default_nettype none

module prr_periph_model (
    input wire logic clk,
    input wire logic [13:0] periphAddr,
    input wire logic periphRead,
    output logic [7:0] periphRdata
);
    logic [7:0] noise = 8'h00;

    // Outside a read the data lines carry a pattern that changes every cycle.
    always @(posedge clk) begin
        noise <= noise + 8'h3b;
    end

    assign periphRdata = periphRead ? (periphAddr[7:0] ^ 8'h5a) : noise;
endmodule
`default_nettype wire

/* tb_page_zero_ram_decoder.sv */
// Self-checking bench for the page-zero decoder against a behavioural model.
// Assumes prr_pkg is compiled first and the decoder holds its own RAM.
`timescale 1ns/1ps
`default_nettype none

module tb_page_zero_ram_decoder;
    localparam logic [13:0] NVM = 14'h3800;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [13:0] busAddr = 14'h0000;
    logic busRead = 1'b0, busWrite = 1'b0, busFetch = 1'b0;
    logic [7:0] busWdata = 8'h00, busRdata, operandAddr, periphWdata, periphRdata;
    logic busRvalid, resetRequest, operandValid, periphRead, periphWrite;
    logic [7:0] opcodeByte = 8'h00;
    logic opcodeValid = 1'b0;
    prr_pkg::prr_form_e opcodeForm = prr_pkg::PRR_FORM_TINY;
    logic [13:0] periphAddr;
    logic [7:0] mem [int];
    logic [7:0] ptr, pg, b;
    int n_errors = 0, checks = 0, f;
    logic [13:0] holeAddr [4] = '{14'h0050, 14'h0100, 14'h0240, 14'h37ff};

    prr_decoder #(.NvmBase(NVM)) prr_decoder_inst (.clk(clk), .rst_b(rst_b), .busAddr(busAddr),
        .busRead(busRead), .busWrite(busWrite), .busFetch(busFetch), .busWdata(busWdata),
        .busRdata(busRdata), .busRvalid(busRvalid), .resetRequest(resetRequest),
        .opcodeByte(opcodeByte), .opcodeValid(opcodeValid), .opcodeForm(opcodeForm),
        .operandAddr(operandAddr), .operandValid(operandValid), .periphAddr(periphAddr),
        .periphRead(periphRead), .periphWrite(periphWrite), .periphWdata(periphWdata),
        .periphRdata(periphRdata));
    prr_periph_model prr_periph_model_inst (.clk(clk), .periphAddr(periphAddr),
        .periphRead(periphRead), .periphRdata(periphRdata));

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Kind of a physical address: 0 RAM, 1 pointer, 2 page select, 3 peripheral, 4 hole.
    function automatic int cls(input logic [13:0] p);
        if (p <= 14'h000e || (p >= 14'h0020 && p <= 14'h004f)) return 0;
        if (p == 14'h000f) return 1;
        if (p == 14'h001f) return 2;
        if (p <= 14'h001e || (p >= 14'h0200 && p <= 14'h023f) || p >= NVM) return 3;
        return 4;
    endfunction

    // One bus access; op 0 read, 1 write, 2 fetch.
    task automatic acc(input int op, input logic [13:0] a, input logic [7:0] d);
        logic [13:0] p;
        logic [7:0] e;
        int k;
        p = (a == 14'h000e) ? {6'h00, ptr} : a;
        if (p >= 14'h00c0 && p <= 14'h00ff) p = {pg, p[5:0]};
        k = cls(p);
        e = k == 0 ? mem[p] : k == 1 ? ptr : k == 2 ? pg : k == 3 ? (p[7:0] ^ 8'h5a) : 8'h00;
        @(posedge clk);
        #1;
        busAddr = a;
        busRead = (op == 0);
        busWrite = (op == 1);
        busFetch = (op == 2);
        busWdata = d;
        #1;
        chk({2'b00, periphAddr}, {2'b00, p});
        chk(periphWrite, op == 1 && k == 3);
        chk(periphRead, op != 1 && k == 3);
        chk(periphWdata, d);
        @(posedge clk);
        #1;
        {busRead, busWrite, busFetch} = 3'b000;
        chk(resetRequest, k == 4);
        if (op != 1) begin
            chk(busRvalid, 1'b1);
            chk(busRdata, e);
        end else if (k == 0) begin
            mem[p] = d;
        end else if (k == 1) begin
            ptr = d;
        end else if (k == 2) begin
            pg = d;
        end
    endtask

    task automatic do_reset;
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        ptr = 8'h00;
        pg = 8'h00;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        n_errors++;
        finish_test();
    end

    initial begin
        f = $urandom(32'h4c2a84ea);
        ptr = 8'h00;
        pg = 8'h00;
        do_reset();
        acc(0, 14'h000f, 8'h00);
        acc(0, 14'h001f, 8'h00);
        for (int i = 0; i < 14; i++) acc(1, i[13:0], 8'($urandom));
        for (int i = 32; i < 80; i++) acc(1, i[13:0], 8'($urandom));
        acc(1, 14'h000f, 8'h0e);
        acc(1, 14'h000e, 8'ha7);
        acc(0, 14'h000e, 8'h00);
        acc(0, 14'h00ce, 8'h00);
        acc(1, 14'h00c5, 8'h3c);
        acc(2, 14'h0005, 8'h00);
        acc(1, 14'h001f, 8'h01);
        acc(0, 14'h00c5, 8'h00);
        acc(0, 14'h00d0, 8'h00);
        acc(1, 14'h000f, 8'h0f);
        acc(0, 14'h000e, 8'h00);
        acc(1, 14'h000e, 8'h2b);
        acc(0, 14'h000f, 8'h00);
        foreach (holeAddr[j]) acc(j % 3, holeAddr[j], 8'h11);
        acc(1, 14'h0010, 8'h44);
        acc(0, 14'h0210, 8'h00);
        acc(2, 14'h3ffd, 8'h00);
        // Back-to-back write and read of one fast RAM byte.
        b = 8'($urandom);
        @(posedge clk);
        #1;
        busAddr = 14'h0005;
        busWdata = b;
        busWrite = 1'b1;
        @(posedge clk);
        #1;
        busWrite = 1'b0;
        busRead = 1'b1;
        mem[5] = b;
        @(posedge clk);
        #1;
        busRead = 1'b0;
        chk(busRdata, b);
        for (int i = 0; i < 60; i++) acc($urandom % 3, ($urandom % 2) ? 14'($urandom % 14) : 14'(32 + $urandom % 48), 8'($urandom));
        for (int i = 0; i < 16; i++) begin
            b = 8'($urandom);
            f = $urandom % 2;
            @(posedge clk);
            #1;
            opcodeValid = 1'b1;
            opcodeByte = b;
            opcodeForm = prr_pkg::prr_form_e'(f);
            @(posedge clk);
            #1;
            opcodeValid = 1'b0;
            chk(operandValid, 1'b1);
            chk(operandAddr, f ? {3'b000, b[4:0]} : {4'h0, b[3:0]});
        end
        repeat (20) @(posedge clk);
        do_reset();
        acc(0, 14'h000f, 8'h00);
        for (int i = 0; i < 14; i++) acc(0, i[13:0], 8'h00);
        for (int i = 32; i < 80; i++) acc(0, i[13:0], 8'h00);
        acc(0, 14'h00ce, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
